// [core/keypad_program_mode_interpreter.sv]
// Keypad data-field programming mode command interpreter
`timescale 1ns/100ps
module keypad_program_mode_interpreter #(
  parameter logic [31:0] POWERUP_COUNT  = keypad_prog_pkg::POWERUP_CYCLES,
  parameter logic [31:0] BEEP_STEP      = keypad_prog_pkg::BEEP_STEP_CYCLES,
  parameter logic [15:0] INSTALLER_CODE = 16'h1234,
  parameter logic [7:0]  REVISION_LEVEL = 8'h10,
  parameter int          PART_COUNT     = 2
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Keypad input
  input  keypad_prog_pkg::key_t          key,
  input  wire logic                      starPoundTogether,
  input  wire logic                      localProgDisable,
  // Status and display
  output logic                           progMode,
  output logic                           menuMode,
  output logic                           lockout,
  output logic                           beeper,
  output keypad_prog_pkg::display_t      disp
);
  import keypad_prog_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  mode_t       mode;
  mode_t       next_mode;
  logic [1:0]  page;
  logic [7:0]  field;
  logic [1:0]  partSel;
  logic        partMode;
  logic        windowOpen;
  logic [31:0] powerCnt;
  logic [27:0] codeShift;
  logic [3:0]  tens;
  logic        haveTens;
  logic [1:0]  menuZeros;
  logic [2:0]  beepPhase;
  logic [31:0] stepCnt;
  command_t    cmd;
  logic [6:0]  readData;

  // Only the two default keypad addresses are heard
  wire keyOk = key.valid && key.source <= KEYPAD_MAX_ADDR;
  key_t keyIn;
  assign keyIn = '{valid: keyOk, code: key.code, source: key.source};

  keypad_digit_collector collector (
    .clock  (clock),
    .rst    (rst),
    .enable (mode == MODE_PROGRAM),
    .key    (keyIn),
    .cmd    (cmd)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire starCmd  = cmd.valid && cmd.star;
  wire poundCmd = cmd.valid && cmd.pound;
  wire digitCmd = cmd.valid && cmd.plain;
  wire [3:0] digit = cmd.num[3:0];
  wire isPartCmd  = starCmd && cmd.num == CMD_PARTITION;
  wire isRevCmd   = starCmd && cmd.num == CMD_REVISION;
  wire isMenuCmd  = starCmd && cmd.num == CMD_MENU;
  wire isNextCmd  = starCmd && cmd.num == CMD_NEXT_PAGE;
  wire isDefCmd   = starCmd && cmd.num == CMD_DEFAULTS;
  wire isLockCmd  = starCmd && cmd.num == CMD_EXIT_LOCK;
  wire isPrevCmd  = starCmd && cmd.num == CMD_PREV_PAGE;
  wire isSpecial  = isPartCmd || isRevCmd || isMenuCmd || isNextCmd ||
                    isDefCmd || isLockCmd || isPrevCmd;
  wire addrCmd    = (starCmd && !isSpecial) || poundCmd;
  wire addrValid  = fieldExists(page, cmd.num);
  wire badAddr    = addrCmd && !addrValid;
  wire goodAddr   = addrCmd && addrValid;

  // Code entry in normal mode: last seven digits against code plus 800
  wire normDigit  = mode == MODE_NORMAL && keyOk && key.code <= 4'h9;
  wire [27:0] next_codeShift = {codeShift[23:0], key.code};
  wire codeHit    = normDigit && !lockout &&
                    next_codeShift == {INSTALLER_CODE, ENTER_SUFFIX};
  wire comboHit   = mode == MODE_NORMAL && windowOpen && starPoundTogether;
  wire enterReq   = (codeHit || comboHit) && !localProgDisable;

  // Value entry: two digits per field
  wire entryDigit = mode == MODE_PROGRAM && digitCmd && !disp.readOnly;
  wire [6:0] entryValue = 7'(tens * 4'hA) + 7'(digit);
  wire secondDigit = entryDigit && haveTens;
  wire outOfRange = secondDigit && entryValue > VALUE_MAX;
  wire writeEn    = secondDigit && !outOfRange;
  // Without the hold, a lone digit or the revision would last one cycle
  wire holdValue  = (haveTens || disp.revision) && !cmd.valid;

  // Advance target, skipping the partition block for global walks
  wire [7:0] stepField = bcdInc(field);
  wire skipPart = !partMode && PART_COUNT > 1 &&
                  isPartField(page, stepField);
  wire [7:0] skipField = skipPart ? bcdInc(PART_FIELD_HI) : stepField;
  wire [7:0] next_field = fieldExists(page, skipField) ? skipField
                          : PAGE_LO[8*(3-page) +: 8];

  // Partition prompt answer
  wire partDigit = mode == MODE_PARTITION && keyOk && key.code <= 4'h9;
  wire partGood  = partDigit && key.code >= 4'h1 &&
                   32'(key.code) <= 32'(PART_COUNT);

  // Menu escape: two zeros then star
  wire menuKey  = mode == MODE_MENU && keyOk;
  wire menuExit = menuKey && key.code == KEY_STAR && menuZeros == 2'h2;

  wire [9:0] storeIdx = {partMode ? partSel[0] : 1'b0, page,
                         bcdToBin(field)};

  keypad_field_store #(
    .ADDR_W (10),
    .DATA_W (7)
  ) store (
    .clock        (clock),
    .rst          (rst),
    .writeEn      (writeEn),
    .writeAddr    (storeIdx),
    .writeData    (entryValue),
    .loadDefaults (mode == MODE_PROGRAM && isDefCmd),
    .readAddr     (storeIdx),
    .readData     (readData)
  );

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_NORMAL: begin
        if (enterReq) next_mode = MODE_PROGRAM;
      end
      MODE_PROGRAM: begin
        if (isLockCmd) next_mode = MODE_NORMAL;
        else if (isPrevCmd && page == FIRST_PAGE)
          next_mode = MODE_NORMAL;
        else if (isPartCmd) next_mode = MODE_PARTITION;
        else if (isMenuCmd) next_mode = MODE_MENU;
      end
      MODE_PARTITION: begin
        if (partGood) next_mode = MODE_PROGRAM;
      end
      MODE_MENU: begin
        if (menuExit) next_mode = MODE_PROGRAM;
      end
      default: next_mode = MODE_NORMAL;
    endcase
  end

  // ****************************************************************
  // Power-up window and beeper divider
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      powerCnt   <= 32'h0000_0000;
      windowOpen <= 1'b1;
    end else if (windowOpen) begin
      powerCnt   <= powerCnt + 32'h0000_0001;
      windowOpen <= powerCnt < POWERUP_COUNT - 32'h0000_0001;
    end
  end

  wire stepTick = stepCnt == BEEP_STEP - 32'h0000_0001;

  // Phases 5, 3 and 1 sound: three beeps per completed field
  always_ff @(posedge clock) begin
    if (rst) begin
      beepPhase <= 3'h0;
      stepCnt   <= 32'h0000_0000;
      beeper    <= 1'b0;
    end else if (writeEn) begin
      beepPhase <= BEEP_PHASES;
      stepCnt   <= 32'h0000_0000;
      beeper    <= 1'b0;
    end else begin
      stepCnt   <= stepTick ? 32'h0000_0000 : stepCnt + 32'h0000_0001;
      if (stepTick && beepPhase != 3'h0) beepPhase <= beepPhase - 3'h1;
      beeper    <= beepPhase[0];
    end
  end

  // ****************************************************************
  // Mode, page, field and lockout
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      mode      <= MODE_NORMAL;
      lockout   <= 1'b0;
      codeShift <= 28'h000_0000;
      page      <= FIRST_PAGE;
      field     <= FIELD_RESET;
      partSel   <= 2'h0;
      partMode  <= 1'b0;
      menuZeros <= 2'h0;
    end else begin
      mode <= next_mode;
      if (normDigit) codeShift <= next_codeShift;
      if (enterReq) begin
        page     <= FIRST_PAGE;
        field    <= FIELD_RESET;
        partMode <= 1'b0;
      end
      if (mode == MODE_PROGRAM) begin
        if (isLockCmd) lockout <= 1'b1;
        if (isNextCmd && page != LAST_PAGE) begin
          page  <= page + 2'h1;
          field <= PAGE_LO[8*(2-page) +: 8];
        end
        if (isPrevCmd && page != FIRST_PAGE) begin
          page  <= page - 2'h1;
          field <= PAGE_LO[8*(4-page) +: 8];
        end
        if (goodAddr) begin
          field    <= cmd.num;
          partMode <= isPartField(page, cmd.num);
        end
        if (writeEn) begin
          field <= next_field;
          if (partMode && !isPartField(page, stepField))
            partMode <= 1'b0;
        end
      end
      if (partGood) partSel <= 2'(key.code - 4'h1);
      if (mode != MODE_MENU) menuZeros <= 2'h0;
      else if (menuKey)
        menuZeros <= key.code == 4'h0 && menuZeros != 2'h2 ?
                     menuZeros + 2'h1 : 2'h0;
    end
  end

  // ****************************************************************
  // Entry digits and display
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      tens     <= 4'h0;
      haveTens <= 1'b0;
      disp     <= '0;
      progMode <= 1'b0;
      menuMode <= 1'b0;
    end else begin
      progMode <= next_mode != MODE_NORMAL;
      menuMode <= next_mode == MODE_MENU;
      // A short entry just sits until a new star or pound command
      if (cmd.valid && !cmd.plain) haveTens <= 1'b0;
      if (entryDigit && !haveTens) begin
        tens     <= digit;
        haveTens <= 1'b1;
      end
      if (secondDigit) haveTens <= 1'b0;
      disp.pagePrefix <= page;
      disp.banner     <= page != FIRST_PAGE;
      disp.field      <= field;
      disp.partition  <= partSel;
      if (entryDigit) disp.value <= 7'(digit);
      else if (!holdValue) disp.value <= readData;
      if (enterReq) disp.readOnly <= 1'b0;
      if (goodAddr) disp.readOnly <= poundCmd;
      if (cmd.valid && !cmd.plain || enterReq) begin
        disp.invalidAddr <= badAddr;
        disp.blank       <= 1'b0;
        disp.revision    <= isRevCmd;
      end
      if (isRevCmd) disp.value <= REVISION_LEVEL[6:0];
      if (outOfRange || (partDigit && !partGood))
        disp.blank <= 1'b1;
      else if (writeEn) disp.blank <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_entry_page_one: assert property ($rose(progMode) |=>
    disp.pagePrefix == FIRST_PAGE) else $error("entry not on page one");
  a_entry_has_cause: assert property ($rose(progMode) |->
    $past(enterReq)) else $error("programming entered without cause");
  a_remote_disable: assert property (localProgDisable &&
    mode == MODE_NORMAL |=> mode == MODE_NORMAL)
    else $error("entered programming while disabled");
  a_page_step_up: assert property (mode == MODE_PROGRAM &&
    isNextCmd && page != LAST_PAGE |=> page == $past(page) + 2'h1)
    else $error("page did not advance");
  a_exit_locks: assert property (mode == MODE_PROGRAM &&
    isLockCmd |=> ##1 !progMode && lockout)
    else $error("exit with lockout failed");
  a_prev_exits_free: assert property (mode == MODE_PROGRAM &&
    isPrevCmd && page == FIRST_PAGE |=> ##1 !progMode &&
    lockout == $past(lockout, 2)) else $error("exit on page one wrong");
  a_view_no_write: assert property (disp.readOnly && digitCmd
    |-> !writeEn ##1 readData == $past(readData))
    else $error("read-only field was written");
  a_range_blanks: assert property (outOfRange |=>
    disp.blank && field == $past(field))
    else $error("bad value not blanked");
  a_bad_addr_shown: assert property (mode == MODE_PROGRAM &&
    badAddr |=> disp.invalidAddr && field == $past(field))
    else $error("invalid address not flagged");
  a_three_beeps: assert property (writeEn |=>
    beepPhase == BEEP_PHASES && field == $past(next_field))
    else $error("completed field did not beep and advance");
  // Page and field registers settle one edge after the command pulse
  a_page_step_down: assert property (mode == MODE_PROGRAM &&
    isPrevCmd && page != FIRST_PAGE |=> page == $past(page) - 2'h1)
    else $error("page did not step back");
  a_page_limit: assert property (mode == MODE_PROGRAM &&
    isNextCmd && page == LAST_PAGE |=> page == LAST_PAGE)
    else $error("page moved past the last page");
  a_menu_entry: assert property (mode == MODE_PROGRAM &&
    isMenuCmd |=> menuMode) else $error("menu mode not entered");
  a_part_select: assert property (partGood |=>
    partSel == 2'($past(key.code) - 4'h1))
    else $error("partition not selected");
  a_skip_part: assert property (writeEn && !partMode &&
    PART_COUNT > 1 |=> !isPartField(page, field))
    else $error("global walk landed on a partition field");
  a_short_holds: assert property (mode == MODE_PROGRAM &&
    haveTens && !cmd.valid |=> disp.value == $past(disp.value))
    else $error("pending digit not kept on display");
  a_defaults_load: assert property (mode == MODE_PROGRAM &&
    isDefCmd |=> readData == DEFAULT_VALUE)
    else $error("defaults not loaded");
  a_revision_shown: assert property (mode == MODE_PROGRAM &&
    isRevCmd |=> disp.revision && disp.value == REVISION_LEVEL[6:0])
    else $error("revision level not shown");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_enter_mode: cover property (enterReq ##1 mode == MODE_PROGRAM);
  c_page_four: cover property (mode == MODE_PROGRAM &&
    page == LAST_PAGE);
  c_field_written: cover property (writeEn ##1 beepPhase != 3'h0);
  c_menu_round: cover property (mode == MODE_MENU ##1 menuExit);
  c_read_only_view: cover property (goodAddr && poundCmd ##1 disp.readOnly);
endmodule : keypad_program_mode_interpreter

// [core/keypad_prog_pkg.sv]
// Constants, types and helper functions for the keypad programming block
// Functional notes
// - A completed field entry gives three beeps and moves to the next field.
// - Enter programming by star+pound within 30 s, or installer code plus 800.
// - Four pages of fields; page one is active on entry.
// - Pages two to four show prefix 1/2/3 and the higher-page banner.
// - Star 94 moves one page up, stopping at page four.
// - Star 99 moves one page down; on page one it exits without lockout.
// - Star 98 exits programming and locks out the installer code.
// - Star 91 prompts for a partition and selects it for later edits.
// - Star 92 shows the firmware revision level.
// - Star 93 switches to the question-and-answer menu mode.
// - Pound plus two digits shows a field read-only and refuses changes.
// - A nonexistent field address shows the invalid-address indicator.
// - An out-of-range value blanks the entry position and stores nothing.
// - Field ranges: page one 00-90, two 01-77, three 00-24, four 00-85.
// - Auto advance skips partition fields unless addressed directly or one partition.
// - A short entry stays shown until a star or pound command arrives.
// - Star 97 loads factory defaults into every field.
// - Under defaults only keypads 00 and 01 are accepted.
// - A remote disable flag blocks entry to programming from the keypad.
package keypad_prog_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint      CLOCK_HZ         = 100_000_000;
  localparam longint      POWERUP_WINDOW_S = 30;
  localparam logic [31:0] POWERUP_CYCLES   =
    32'(POWERUP_WINDOW_S * CLOCK_HZ);
  localparam longint      BEEP_STEP_MS     = 100;
  localparam logic [31:0] BEEP_STEP_CYCLES =
    32'(BEEP_STEP_MS * CLOCK_HZ / 1000);
  localparam logic [2:0]  BEEP_PHASES      = 3'h6;

  // ****************************************************************
  // Keys, commands and field map
  // ****************************************************************
  localparam logic [3:0]  KEY_STAR        = 4'hA;
  localparam logic [3:0]  KEY_POUND       = 4'hB;
  localparam logic [11:0] ENTER_SUFFIX    = 12'h800;
  localparam logic [7:0]  CMD_PARTITION   = 8'h91;
  localparam logic [7:0]  CMD_REVISION    = 8'h92;
  localparam logic [7:0]  CMD_MENU        = 8'h93;
  localparam logic [7:0]  CMD_NEXT_PAGE   = 8'h94;
  localparam logic [7:0]  CMD_DEFAULTS    = 8'h97;
  localparam logic [7:0]  CMD_EXIT_LOCK   = 8'h98;
  localparam logic [7:0]  CMD_PREV_PAGE   = 8'h99;
  localparam logic [1:0]  FIRST_PAGE      = 2'h0;
  localparam logic [1:0]  LAST_PAGE       = 2'h3;
  localparam logic [31:0] PAGE_LO         = 32'h00_01_00_00;
  localparam logic [31:0] PAGE_HI         = 32'h90_77_24_85;
  localparam logic [7:0]  PART_FIELD_LO   = 8'h09;
  localparam logic [7:0]  PART_FIELD_HI   = 8'h29;
  localparam logic [4:0]  KEYPAD_MAX_ADDR = 5'h01;
  localparam logic [6:0]  VALUE_MAX       = 7'h3F;
  localparam logic [6:0]  DEFAULT_VALUE   = 7'h00;
  localparam logic [7:0]  FIELD_RESET     = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_PROGRAM, MODE_PARTITION, MODE_MENU
  } mode_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
    logic [4:0] source;
  } key_t;

  typedef struct packed {
    logic       valid;
    logic       star;
    logic       pound;
    logic       plain;
    logic [7:0] num;
  } command_t;

  typedef struct packed {
    logic [1:0] pagePrefix;
    logic [7:0] field;
    logic [6:0] value;
    logic       blank;
    logic       invalidAddr;
    logic       banner;
    logic       readOnly;
    logic       revision;
    logic [1:0] partition;
  } display_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] bcdToBin(input logic [7:0] bcd);
    bcdToBin = 7'(bcd[7:4] * 4'hA) + 7'(bcd[3:0]);
  endfunction : bcdToBin

  function automatic logic fieldExists(input logic [1:0] pg,
                                       input logic [7:0] fld);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = PAGE_LO[8*(3-pg) +: 8];
    hi = PAGE_HI[8*(3-pg) +: 8];
    fieldExists = fld[3:0] <= 4'h9 && fld >= lo && fld <= hi;
  endfunction : fieldExists

  function automatic logic isPartField(input logic [1:0] pg,
                                       input logic [7:0] fld);
    isPartField = pg == FIRST_PAGE && fld >= PART_FIELD_LO &&
                  fld <= PART_FIELD_HI;
  endfunction : isPartField

  function automatic logic [7:0] bcdInc(input logic [7:0] bcd);
    bcdInc = bcd[3:0] == 4'h9 ? {bcd[7:4] + 4'h1, 4'h0}
                              : {bcd[7:4], bcd[3:0] + 4'h1};
  endfunction : bcdInc

endpackage : keypad_prog_pkg

// [core/keypad_digit_collector.sv]
// Collects star or pound plus two digits into one command
`timescale 1ns/100ps
module keypad_digit_collector (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Key stream
  input  wire logic                      enable,
  input  keypad_prog_pkg::key_t          key,
  // Decoded command
  output keypad_prog_pkg::command_t      cmd
);
  import keypad_prog_pkg::*;

  logic       armed;
  logic       isStar;
  logic       haveTens;
  logic [3:0] tens;

  wire isDigit  = key.valid && key.code <= 4'h9;
  wire isPrefix = key.valid && (key.code == KEY_STAR ||
                                key.code == KEY_POUND);

  // A prefixed command is not decoded until its second digit lands
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      armed    <= 1'b0;
      isStar   <= 1'b0;
      haveTens <= 1'b0;
      tens     <= 4'h0;
      cmd      <= '0;
    end else begin
      cmd <= '0;
      if (isPrefix) begin
        armed    <= 1'b1;
        isStar   <= key.code == KEY_STAR;
        haveTens <= 1'b0;
      end else if (isDigit && armed && !haveTens) begin
        tens     <= key.code;
        haveTens <= 1'b1;
      end else if (isDigit && armed) begin
        cmd   <= '{valid: 1'b1, star: isStar, pound: !isStar,
                   plain: 1'b0, num: {tens, key.code}};
        armed <= 1'b0;
      end else if (isDigit) begin
        cmd <= '{valid: 1'b1, star: 1'b0, pound: 1'b0,
                 plain: 1'b1, num: {4'h0, key.code}};
      end
    end
  end
endmodule : keypad_digit_collector

// [core/keypad_field_store.sv]
// Flip-flop storage for all data fields with bulk default load
`timescale 1ns/100ps
module keypad_field_store #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 7
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Write side
  input  wire logic              writeEn,
  input  wire logic [ADDR_W-1:0] writeAddr,
  input  wire logic [DATA_W-1:0] writeData,
  input  wire logic              loadDefaults,
  // Read side
  input  wire logic [ADDR_W-1:0] readAddr,
  output logic      [DATA_W-1:0] readData
);
  import keypad_prog_pkg::*;

  logic [DATA_W-1:0] mem [2**ADDR_W];

  assign readData = mem[readAddr];

  // Default load wins over a same-cycle write
  always_ff @(posedge clock) begin
    if (rst || loadDefaults) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem[i] <= DATA_W'(DEFAULT_VALUE);
      end
    end else if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
  end
endmodule : keypad_field_store

// [verif/keypad_installer_model.sv]
// Installer at a keypad: presses single keys and the star-pound pair
`timescale 1ns/100ps
module keypad_installer_model (
  // Clock
  input  wire logic             clock,
  // Keypad lines
  output keypad_prog_pkg::key_t key,
  output logic                  starPoundTogether
);
  import keypad_prog_pkg::*;

  initial begin
    key = '0;
    starPoundTogether = 1'b0;
  end

  // Released lines carry inverted data so stale values never match
  task automatic press(input logic [3:0] code, input logic [4:0] src);
    @(negedge clock);
    key = '{valid: 1'b1, code: code, source: src};
    @(negedge clock);
    key = '{valid: 1'b0, code: ~code, source: ~src};
  endtask : press

  task automatic pressPair();
    @(negedge clock);
    starPoundTogether = 1'b1;
    @(negedge clock);
    starPoundTogether = 1'b0;
  endtask : pressPair
endmodule : keypad_installer_model

// [verif/tb.sv]
// Self-checking bench for the keypad programming interpreter
`timescale 1ns/100ps
module tb;
  import keypad_prog_pkg::*;
  localparam logic [15:0] CODE = 16'h1234;
  localparam logic [7:0]  REV  = 8'h10;
  logic     clock;
  logic     rst;
  logic     localProgDisable;
  logic     progMode;
  logic     menuMode;
  logic     lockout;
  logic     beeper;
  logic     starPoundTogether;
  key_t     key;
  display_t disp;
  int       fail_count = 0;
  int       cmp_count = 0;

  keypad_installer_model u_pad (.clock(clock), .key(key),
    .starPoundTogether(starPoundTogether));
  keypad_program_mode_interpreter #(.POWERUP_COUNT(32'h32),
    .BEEP_STEP(32'h4), .INSTALLER_CODE(CODE), .REVISION_LEVEL(REV))
    u_dut (.clock(clock),
    .rst(rst), .key(key), .starPoundTogether(starPoundTogether),
    .localProgDisable(localProgDisable), .progMode(progMode),
    .menuMode(menuMode), .lockout(lockout), .beeper(beeper), .disp(disp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Display lags the second digit by three edges; four leaves margin
  task automatic cmd(input logic [3:0] pfx, input logic [7:0] num);
    u_pad.press(pfx, 5'h00);
    u_pad.press(num[7:4], 5'h00);
    u_pad.press(num[3:0], 5'h00);
    repeat (4) @(negedge clock);
  endtask : cmd

  task automatic enterCode(input logic [4:0] src);
    for (int i = 3; i >= 0; i--) u_pad.press(CODE[4*i +: 4], src);
    u_pad.press(4'h8, src);
    u_pad.press(4'h0, src);
    u_pad.press(4'h0, src);
    repeat (4) @(negedge clock);
  endtask : enterCode

  task automatic doReset();
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
  endtask : doReset

  task automatic t_pages();
    doReset();
    enterCode(5'h02);
    check(progMode, 1'b0);
    enterCode(5'h01);
    check(progMode, 1'b1);
    check({disp.pagePrefix, disp.banner}, 3'h0);
    u_pad.press(KEY_STAR, 5'h00);
    u_pad.press(CMD_NEXT_PAGE[7:4], 5'h00);
    repeat (4) @(negedge clock);
    check(disp.pagePrefix, 2'h0);
    for (int i = 1; i <= 4; i++) begin
      cmd(KEY_STAR, CMD_NEXT_PAGE);
      check({disp.pagePrefix, disp.banner}, i > 3 ? 7 : 2*i + 1);
    end
    check(disp.pagePrefix, 2'h3);
    cmd(KEY_STAR, CMD_PREV_PAGE);
    check(disp.pagePrefix, 2'h2);
    for (int i = 0; i < 3; i++) cmd(KEY_STAR, CMD_PREV_PAGE);
    check({progMode, lockout}, 2'h0);
  endtask : t_pages

  task automatic t_fields();
    int n;
    doReset();
    u_pad.pressPair();
    repeat (2) @(negedge clock);
    check(progMode, 1'b1);
    cmd(KEY_STAR, 8'h95);
    check(disp.invalidAddr, 1'b1);
    cmd(KEY_STAR, 8'h08);
    check({disp.invalidAddr, disp.field}, 9'h008);
    u_pad.press(4'h1, 5'h00);
    u_pad.press(4'h2, 5'h00);
    n = 0;
    while (beeper !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check(n < 40, 1'b1);
    check(disp.field, 8'h30);
    u_pad.press(4'h9, 5'h00);
    u_pad.press(4'h9, 5'h00);
    repeat (4) @(negedge clock);
    check(disp.blank, 1'b1);
    u_pad.press(4'h5, 5'h00);
    repeat (4) @(negedge clock);
    check(disp.value, 7'h05);
    cmd(KEY_POUND, 8'h08);
    u_pad.press(4'h3, 5'h00);
    u_pad.press(4'h4, 5'h00);
    repeat (4) @(negedge clock);
    check({disp.readOnly, disp.value}, 8'h8C);
    cmd(KEY_STAR, CMD_REVISION);
    check({disp.revision, disp.value}, {1'b1, REV[6:0]});
    cmd(KEY_STAR, CMD_PARTITION);
    cmd(4'h2, 8'h00);
    check(disp.partition, 2'h1);
    cmd(KEY_STAR, CMD_MENU);
    check(menuMode, 1'b1);
    cmd(4'h0, {4'h0, KEY_STAR});
    check({menuMode, progMode}, 2'h1);
    cmd(KEY_STAR, CMD_DEFAULTS);
    cmd(KEY_POUND, 8'h08);
    check(disp.value, DEFAULT_VALUE);
    cmd(KEY_STAR, CMD_EXIT_LOCK);
    enterCode(5'h00);
    check({progMode, lockout}, 2'h1);
  endtask : t_fields

  task automatic t_refuse();
    doReset();
    localProgDisable = 1'b1;
    u_pad.pressPair();
    enterCode(5'h00);
    check(progMode, 1'b0);
    localProgDisable = 1'b0;
    repeat (60) @(negedge clock);
    u_pad.pressPair();
    repeat (2) @(negedge clock);
    check(progMode, 1'b0);
  endtask : t_refuse

  initial begin
    rst = 1'b1;
    localProgDisable = 1'b0;
    t_pages();
    t_fields();
    t_refuse();
    test_done();
  end
endmodule : tb
